//--- core/epm_pkg.sv
// Package with constants, register map and carrier types of the monitor bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package epm_pkg;

  // --------------------------------------------------------------------------
  // Page and register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] EPM_PAGE         = 8'h04;
  localparam logic [4:0] EPM_SEQ_ERR      = 5'h10;
  localparam logic [4:0] EPM_SUBMF        = 5'h11;
  localparam logic [4:0] EPM_IRQ_VEC      = 5'h12;
  localparam logic [4:0] EPM_FAR_HI       = 5'h13;
  localparam logic [4:0] EPM_FAR_LO       = 5'h14;
  localparam logic [4:0] EPM_JITTER       = 5'h15;
  localparam logic [4:0] EPM_OVF_LATCH    = 5'h16;
  localparam logic [4:0] EPM_FRAME_LOSS   = 5'h17;
  localparam logic [4:0] EPM_ERR_RATE     = 5'h18;
  localparam logic [4:0] EPM_RCRC         = 5'h19;
  localparam logic [4:0] EPM_ERR_ALIGN    = 5'h1a;
  localparam logic [4:0] EPM_ALARM_LATCH  = 5'h1b;
  localparam logic [4:0] EPM_LINE_HI      = 5'h1c;
  localparam logic [4:0] EPM_LINE_LO      = 5'h1d;
  localparam logic [4:0] EPM_CHK_HI       = 5'h1e;
  localparam logic [4:0] EPM_CHK_LO       = 5'h1f;

  // --------------------------------------------------------------------------
  // Overflow latch bit positions
  // --------------------------------------------------------------------------
  localparam int EPM_OVF_SEQ    = 7;
  localparam int EPM_OVF_FAR    = 6;
  localparam int EPM_OVF_JIT    = 5;
  localparam int EPM_OVF_FLOSS  = 4;
  localparam int EPM_OVF_RATE   = 3;
  localparam int EPM_OVF_ALIGN  = 2;
  localparam int EPM_OVF_LINE   = 1;
  localparam int EPM_OVF_CHK    = 0;

  // --------------------------------------------------------------------------
  // Reset values, margins and times
  // --------------------------------------------------------------------------
  localparam logic [7:0] EPM_RESET_BYTE   = 8'h00;
  localparam int         EPM_NEAR_MARGIN  = 4;
  localparam int         EPM_CLK_KHZ      = 40000;
  localparam int         EPM_RCRC_MIN_MS  = 10;
  localparam int         EPM_RCRC_MAX_MS  = 450;
  localparam int         EPM_RCRC_MIN_CYC = EPM_RCRC_MIN_MS * EPM_CLK_KHZ;
  localparam int         EPM_RCRC_MAX_CYC = EPM_RCRC_MAX_MS * EPM_CLK_KHZ;
  localparam int         EPM_PERSIST_W    = 25;

  // --------------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [7:0] page;
    logic [4:0] addr;
    logic [7:0] wdata;
  } epm_host_type;

  typedef struct packed {
    logic seq_err;
    logic submf_rx;
    logic far_err;
    logic rate_err;
    logic align_err;
    logic line_err;
    logic chk_err;
    logic frame_tick;
    logic irq_raise;
  } epm_event_type;

  typedef struct packed {
    logic remote;
    logic all_ones;
    logic slot16;
    logic signal_loss;
    logic auxiliary;
    logic multiframe;
    logic slip;
  } epm_alarm_type;

endpackage

//--- core/epm_perf_mon.sv
// Performance monitoring register bank, page 04H, with its event counters
`timescale 1ns/1ps
`default_nettype none

module epm_perf_mon
  import epm_pkg::*;
#(
  parameter int unsigned JB_DEPTH         = 64,
  parameter int unsigned JB_FW            = 7,
  parameter int unsigned RCRC_MIN_CYCLES  = EPM_RCRC_MIN_CYC,
  parameter int unsigned RCRC_MAX_CYCLES  = EPM_RCRC_MAX_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire epm_host_type      host,
  input  wire epm_event_type     ev,
  input  wire epm_alarm_type     alarm,
  input  wire logic [7:0]        irq_category,
  input  wire logic              sync_lost,
  input  wire logic              remote_crc_cond,
  input  wire logic [JB_FW-1:0]  jb_fill,
  output logic [7:0]             rdata_r,
  output logic                   rvalid_r,
  output logic                   read_slow_r,
  output logic                   read_fast_r
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]               seq;
    logic [7:0]               submf;
    logic [7:0]               ivec;
    logic [9:0]               far;
    logic [7:0]               jit;
    logic [7:0]               ovf;
    logic [7:0]               floss;
    logic [7:0]               rate;
    logic                     rcrc_window;
    logic                     rcrc_persist;
    logic [7:0]               align;
    logic [6:0]               alarms;
    logic [15:0]              line;
    logic [9:0]               chk;
    logic [EPM_PERSIST_W-1:0] persist;
    logic                     near_prev;
    logic                     lost_prev;
    logic [7:0]               rdata;
    logic                     rvalid;
    logic                     slow;
    logic                     fast;
  } epm_state_type;

  epm_state_type r, r_nxt;

  localparam logic [EPM_PERSIST_W-1:0] MIN_C =
    EPM_PERSIST_W'(RCRC_MIN_CYCLES);
  localparam logic [EPM_PERSIST_W-1:0] MAX_C =
    EPM_PERSIST_W'(RCRC_MAX_CYCLES);
  localparam logic [JB_FW-1:0] LOW_MARK  = JB_FW'(EPM_NEAR_MARGIN);
  localparam logic [JB_FW-1:0] HIGH_MARK = JB_FW'(JB_DEPTH - EPM_NEAR_MARGIN);

  logic       sel;
  logic       rd_hit;
  logic       wr_seq;
  logic       near_lo;
  logic       near_hi;
  logic       near_entry;
  logic       lost_edge;
  logic [7:0] ovf_set;
  logic [7:0] rd_val;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  assign sel    = host.cs && (host.page == EPM_PAGE) && host.addr[4];
  assign rd_hit = sel && host.rd;
  assign wr_seq = sel && host.wr && (host.addr == EPM_SEQ_ERR);

  assign near_lo    = (jb_fill <= LOW_MARK);
  assign near_hi    = (jb_fill >= HIGH_MARK);
  assign near_entry = (near_lo || near_hi) && !r.near_prev;
  assign lost_edge  = sync_lost && !r.lost_prev;

  // Overflow on the increment that wraps each counter but the submultiframe tally
  always_comb begin
    ovf_set                = 8'h00;
    ovf_set[EPM_OVF_SEQ]   = ev.seq_err && !wr_seq && (r.seq == 8'hff);
    ovf_set[EPM_OVF_FAR]   = ev.far_err && (r.far == 10'h3ff);
    ovf_set[EPM_OVF_JIT]   = near_entry && (r.jit == 8'hff);
    ovf_set[EPM_OVF_FLOSS] = ev.frame_tick && sync_lost && !lost_edge &&
                             (r.floss == 8'hff);
    ovf_set[EPM_OVF_RATE]  = ev.rate_err && (r.rate == 8'hff);
    ovf_set[EPM_OVF_ALIGN] = ev.align_err && (r.align == 8'hff);
    ovf_set[EPM_OVF_LINE]  = ev.line_err && (r.line == 16'hffff);
    ovf_set[EPM_OVF_CHK]   = ev.chk_err && (r.chk == 10'h3ff);
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  always_comb begin
    rd_val = EPM_RESET_BYTE;
    unique case (host.addr)
      EPM_SEQ_ERR:     rd_val = r.seq;
      EPM_SUBMF:       rd_val = r.submf;
      EPM_IRQ_VEC:     rd_val = r.ivec;
      EPM_FAR_HI:      rd_val = {6'h00, r.far[9:8]};
      EPM_FAR_LO:      rd_val = r.far[7:0];
      EPM_JITTER:      rd_val = r.jit;
      EPM_OVF_LATCH:   rd_val = r.ovf;
      EPM_FRAME_LOSS:  rd_val = r.floss;
      EPM_ERR_RATE:    rd_val = r.rate;
      EPM_RCRC:        rd_val = {6'h00, r.rcrc_window, r.rcrc_persist};
      EPM_ERR_ALIGN:   rd_val = r.align;
      EPM_ALARM_LATCH: rd_val = {r.alarms, 1'b0};
      EPM_LINE_HI:     rd_val = r.line[15:8];
      EPM_LINE_LO:     rd_val = r.line[7:0];
      EPM_CHK_HI:      rd_val = {6'h00, r.chk[9:8]};
      EPM_CHK_LO:      rd_val = r.chk[7:0];
      default:         rd_val = EPM_RESET_BYTE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    r_nxt = r;

    // Host write wins over a same-cycle error so the loaded value is exact
    if (wr_seq) begin
      r_nxt.seq = host.wdata;
    end else if (ev.seq_err) begin
      r_nxt.seq = r.seq + 8'h01;
    end

    if (wr_seq) begin
      r_nxt.submf = 8'h00;
    end else if (ev.submf_rx) begin
      r_nxt.submf = r.submf + 8'h01;
    end

    if (ev.irq_raise) begin
      r_nxt.ivec = irq_category;
    end

    if (ev.far_err) begin
      r_nxt.far = r.far + 10'h001;
    end

    r_nxt.near_prev = near_lo || near_hi;
    if (near_entry) begin
      r_nxt.jit = r.jit + 8'h01;
    end
    r_nxt.slow = near_lo;
    r_nxt.fast = near_hi;

    r_nxt.lost_prev = sync_lost;
    if (lost_edge) begin
      r_nxt.floss = 8'h00;
    end else if (ev.frame_tick && sync_lost) begin
      r_nxt.floss = r.floss + 8'h01;
    end

    if (ev.rate_err) begin
      r_nxt.rate = r.rate + 8'h01;
    end
    if (ev.align_err) begin
      r_nxt.align = r.align + 8'h01;
    end
    if (ev.line_err) begin
      r_nxt.line = r.line + 16'h0001;
    end
    if (ev.chk_err) begin
      r_nxt.chk = r.chk + 10'h001;
    end

    // Clear on read first, then new events, so a set is never lost
    if (rd_hit && (host.addr == EPM_OVF_LATCH)) begin
      r_nxt.ovf = 8'h00;
    end
    r_nxt.ovf = r_nxt.ovf | ovf_set;

    if (rd_hit && (host.addr == EPM_ALARM_LATCH)) begin
      r_nxt.alarms = 7'h00;
    end
    r_nxt.alarms = r_nxt.alarms | alarm;

    // Persistence timer saturates so a long condition cannot wrap
    if (!remote_crc_cond) begin
      r_nxt.persist = '0;
    end else if (r.persist != '1) begin
      r_nxt.persist = r.persist + EPM_PERSIST_W'(1);
    end
    r_nxt.rcrc_persist = remote_crc_cond && (r.persist > MIN_C);

    if (rd_hit && (host.addr == EPM_RCRC)) begin
      r_nxt.rcrc_window = 1'b0;
    end
    // Window bit marks a condition that ended between the two limits
    if (!remote_crc_cond && (r.persist > MIN_C) && (r.persist < MAX_C)) begin
      r_nxt.rcrc_window = 1'b1;
    end

    r_nxt.rvalid = rd_hit;
    r_nxt.rdata  = rd_hit ? rd_val : EPM_RESET_BYTE;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign rdata_r     = r.rdata;
  assign rvalid_r    = r.rvalid;
  assign read_slow_r = r.slow;
  assign read_fast_r = r.fast;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  seq_err_incr_a: assert property (
    ev.seq_err && !wr_seq |=> r.seq == $past(r.seq) + 8'h01)
    else $error("sequence error tally did not advance");

  submf_write_clear_a: assert property (
    wr_seq |=> r.submf == 8'h00 && r.seq == $past(host.wdata))
    else $error("write did not clear submultiframe tally");

  submf_count_a: assert property (
    ev.submf_rx && !wr_seq |=> r.submf == $past(r.submf) + 8'h01)
    else $error("submultiframe tally did not advance");

  unmapped_zero_a: assert property (
    host.rd && (!host.cs || host.page != EPM_PAGE || !host.addr[4])
    |=> rdata_r == 8'h00 && !rvalid_r)
    else $error("access outside bank answered");

  ovf_flag_set_a: assert property (
    ev.chk_err && r.chk == 10'h3ff |=> r.ovf[EPM_OVF_CHK] && r.chk == 10'h000)
    else $error("checksum overflow flag not set on wrap");

  ovf_read_clear_a: assert property (
    rd_hit && host.addr == EPM_OVF_LATCH && ovf_set == 8'h00
    |=> r.ovf == 8'h00 ##0 rdata_r == $past(r.ovf))
    else $error("overflow latch not cleared by read");

  alarm_set_wins_a: assert property (
    rd_hit && host.addr == EPM_ALARM_LATCH && alarm.slip |=> r.alarms[0])
    else $error("alarm lost on clearing read");

  floss_clear_a: assert property (
    $rose(sync_lost) |=> r.floss == 8'h00)
    else $error("frame loss tally not cleared on loss");

  jit_entry_a: assert property (
    near_entry |=> r.jit == $past(r.jit) + 8'h01 ##1 r.jit == $past(r.jit))
    else $error("jitter tally wrong on margin entry");

  near_slow_a: assert property (
    near_lo |=> read_slow_r && !read_fast_r)
    else $error("read clock not slowed near underflow");

  persist_bit_a: assert property (
    remote_crc_cond && r.persist > MIN_C |=> r.rcrc_persist)
    else $error("persist bit missing after limit");

  persist_drop_a: assert property (
    !remote_crc_cond |=> !r.rcrc_persist)
    else $error("persist bit stayed after condition end");

  line_bytes_a: assert property (
    rd_hit && host.addr == EPM_LINE_HI |=> rdata_r == $past(r.line[15:8]))
    else $error("violation upper byte misread");

  far_hi_zero_a: assert property (
    rd_hit && host.addr == EPM_FAR_HI |=> rdata_r[7:2] == 6'h00)
    else $error("unused far-end bits not zero");

  align_count_a: assert property (
    ev.align_err |=> r.align == $past(r.align) + 8'h01)
    else $error("errored alignment tally did not advance");

  far_incr_a: assert property (
    ev.far_err |=> r.far == $past(r.far) + 10'h001)
    else $error("far-end error tally did not advance");

  rate_incr_a: assert property (
    ev.rate_err |=> r.rate == $past(r.rate) + 8'h01)
    else $error("error rate tally did not advance");

  line_incr_a: assert property (
    ev.line_err |=> r.line == $past(r.line) + 16'h0001)
    else $error("violation tally did not advance");

  chk_incr_a: assert property (
    ev.chk_err |=> r.chk == $past(r.chk) + 10'h001)
    else $error("checksum error tally did not advance");

  chk_hi_zero_a: assert property (
    rd_hit && host.addr == EPM_CHK_HI |=> rdata_r[7:2] == 6'h00)
    else $error("unused checksum bits not zero");

  floss_tick_a: assert property (
    ev.frame_tick && sync_lost && !lost_edge
    |=> r.floss == $past(r.floss) + 8'h01)
    else $error("frame loss tally did not advance");

  ivec_capture_a: assert property (
    ev.irq_raise |=> r.ivec == $past(irq_category))
    else $error("interrupt category not captured");

  ivec_hold_a: assert property (
    !ev.irq_raise |=> $stable(r.ivec))
    else $error("interrupt category changed without raise");

  alarm_clear_a: assert property (
    rd_hit && host.addr == EPM_ALARM_LATCH && alarm == 7'h00
    |=> r.alarms == 7'h00)
    else $error("alarm latch not cleared by read");

  seq_read_a: assert property (
    rd_hit && host.addr == EPM_SEQ_ERR
    |=> rvalid_r && rdata_r == $past(r.seq))
    else $error("sequence tally read not answered");

  near_fast_a: assert property (
    near_hi |=> read_fast_r && !read_slow_r)
    else $error("read clock not sped up near overflow");

  window_set_a: assert property (
    !remote_crc_cond && r.persist > MIN_C && r.persist < MAX_C
    |=> r.rcrc_window)
    else $error("window bit missing after bounded episode");

endmodule

`default_nettype wire

//--- sim/epm_host_model.sv
// Host processor model driving the page-select register bus
`timescale 1ns/1ps
`default_nettype none

module epm_host_model
  import epm_pkg::*;
(
  input  wire logic   clk,
  output var epm_host_type host
);
  initial host = '0;

  // ---------------------------------------------------------------
  // One strobe cycle; released lines show the inverse, not the last
  // ---------------------------------------------------------------
  task automatic access(input logic r, input logic w,
                        input logic [7:0] pg, input logic [4:0] a,
                        input logic [7:0] d);
    @(negedge clk);
    host <= '{cs: 1'b1, rd: r, wr: w, page: pg, addr: a, wdata: d};
    @(negedge clk);
    host <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, page: ~pg, addr: ~a,
              wdata: ~d};
  endtask
endmodule

`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the monitor register bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module testbench;
  import epm_pkg::*;

  logic          clk = 1'b0;
  logic          reset = 1'b1;
  epm_host_type  host;
  epm_event_type ev = '0;
  epm_alarm_type alarm = '0;
  logic [7:0]    irq_category = 8'h00;
  logic          sync_lost = 1'b0;
  logic          remote_crc_cond = 1'b0;
  logic [6:0]    jb_fill = 7'h20;
  logic [7:0]    rdata_r;
  logic          rvalid_r;
  logic          read_slow_r;
  logic          read_fast_r;
  logic [7:0]    q[$];
  int            fails = 0;
  int            checks = 0;
  int            n;
  logic [7:0]    v;
  logic [7:0]    want;
  logic [7:0]    far_hi;
  logic [4:0]    lo_a [8] = '{5'h10, 5'h11, 5'h14, 5'h18, 5'h1a, 5'h1d,
                              5'h1f, 5'h17};
  int            wide [8] = '{0, 0, 1, 0, 0, 1, 1, 0};
  logic [6:0]    fills [7] = '{7'd32, 7'd4, 7'd5, 7'd60, 7'd59, 7'd0,
                               7'd32};
  logic [6:0]    slow_e = 7'b0100010;
  logic [6:0]    fast_e = 7'b0001000;

  always #12.5 clk = ~clk;

  epm_host_model epm_host_model_inst (.clk(clk), .host(host));

  epm_perf_mon #(
    .JB_DEPTH        (64),
    .JB_FW           (7),
    .RCRC_MIN_CYCLES (20),
    .RCRC_MAX_CYCLES (100)
  ) epm_perf_mon_inst (
    .clk             (clk),
    .reset           (reset),
    .host            (host),
    .ev              (ev),
    .alarm           (alarm),
    .irq_category    (irq_category),
    .sync_lost       (sync_lost),
    .remote_crc_cond (remote_crc_cond),
    .jb_fill         (jb_fill),
    .rdata_r         (rdata_r),
    .rvalid_r        (rvalid_r),
    .read_slow_r     (read_slow_r),
    .read_fast_r     (read_fast_r)
  );

  // ---------------------------------------------------------------
  // Output watcher: each answer takes the oldest note
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (!reset) begin
      if (rvalid_r === 1'b1) begin
        if (q.size() == 0) begin
          `CHK(1'b0, 1'b1)
        end else begin
          want = q.pop_front();
          `CHK(rdata_r, want)
        end
      end else begin
        `CHK(rdata_r, 8'h00)
      end
    end
  end

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    q.push_back(e);
    epm_host_model_inst.access(1'b1, 1'b0, EPM_PAGE, a, 8'h00);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    epm_host_model_inst.access(1'b0, 1'b1, EPM_PAGE, a, d);
  endtask

  task automatic pulse(input logic [8:0] m, input int cnt);
    repeat (cnt) begin
      @(negedge clk);
      ev <= m;
    end
    @(negedge clk);
    ev <= '0;
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (5) @(negedge clk);
    reset <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bounded run; a hang counts against the result
  initial begin
    #2400000;
    fails++;
    final_report();
  end

  initial begin
    void'($urandom(32'h2549));
    do_reset();
    for (int a = 16; a < 32; a++) rd(5'(a), 8'h00);
    epm_host_model_inst.access(1'b1, 1'b0, 8'h03, 5'h10, 8'h00);
    epm_host_model_inst.access(1'b1, 1'b0, EPM_PAGE, 5'h0f, 8'h00);
    $display("test reset values done");

    // Every counter but the submultiframe tally wraps in one run; line counter needs the full span
    sync_lost <= 1'b1;
    for (int i = 0; i < 65536; i++) begin
      @(negedge clk);
      ev <= {i < 256, 1'b0, i < 1024, i < 256, i < 256, 1'b1, i < 1024,
             i < 256, 1'b0};
      jb_fill <= (i < 512 && i % 2 == 1) ? 7'd2 : 7'd32;
    end
    @(negedge clk);
    ev <= '0;
    rd(EPM_OVF_LATCH, 8'hff);
    rd(EPM_OVF_LATCH, 8'h00);
    rd(EPM_JITTER, 8'h00);
    rd(EPM_LINE_HI, 8'h00);
    $display("test overflow done");

    do_reset();
    sync_lost <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      n = wide[k] ? $urandom_range(1023, 256) : $urandom_range(255, 1);
      pulse(9'h100 >> k, n);
      if (k == 2) far_hi = 8'(n >> 8);
      rd(lo_a[k], n[7:0]);
      if (wide[k] != 0) rd(5'(lo_a[k] - 5'h1), 8'(n >> 8));
    end
    sync_lost <= 1'b0;
    pulse(9'h002, 5);
    sync_lost <= 1'b1;
    pulse(9'h002, 3);
    rd(EPM_FRAME_LOSS, 8'h03);
    $display("test counters done");

    v = 8'($urandom);
    irq_category <= v;
    pulse(9'h001, 1);
    irq_category <= ~v;
    rd(EPM_IRQ_VEC, v);
    n = $urandom_range(255, 0);
    wr(EPM_SEQ_ERR, n[7:0]);
    rd(EPM_SEQ_ERR, n[7:0]);
    rd(EPM_SUBMF, 8'h00);
    wr(EPM_IRQ_VEC, ~v);
    wr(EPM_FAR_HI, 8'hff);
    rd(EPM_IRQ_VEC, v);
    rd(EPM_FAR_HI, far_hi);
    $display("test writes done");

    for (int i = 0; i < 6; i++) begin
      alarm <= 7'($urandom_range(127, 1));
      @(negedge clk);
      v = {alarm, 1'b0};
      alarm <= '0;
      rd(EPM_ALARM_LATCH, v);
      rd(EPM_ALARM_LATCH, 8'h00);
    end
    $display("test alarms done");

    for (int i = 0; i < 7; i++) begin
      jb_fill <= fills[i];
      repeat (2) @(negedge clk);
      `CHK(read_slow_r, slow_e[6 - i])
      `CHK(read_fast_r, fast_e[6 - i])
    end
    rd(EPM_JITTER, 8'h03);
    $display("test jitter done");

    remote_crc_cond <= 1'b1;
    repeat (30) @(negedge clk);
    rd(EPM_RCRC, 8'h01);
    remote_crc_cond <= 1'b0;
    repeat (3) @(negedge clk);
    rd(EPM_RCRC, 8'h02);
    rd(EPM_RCRC, 8'h00);
    remote_crc_cond <= 1'b1;
    repeat (10) @(negedge clk);
    remote_crc_cond <= 1'b0;
    repeat (3) @(negedge clk);
    rd(EPM_RCRC, 8'h00);
    remote_crc_cond <= 1'b1;
    repeat (150) @(negedge clk);
    rd(EPM_RCRC, 8'h01);
    remote_crc_cond <= 1'b0;
    repeat (3) @(negedge clk);
    rd(EPM_RCRC, 8'h00);
    $display("test combined alarm done");

    for (int i = 0; i < 10 && q.size() != 0; i++) @(negedge clk);
    if (q.size() != 0) fails++;
    final_report();
  end
endmodule

`default_nettype wire
